// ==== common/sorter_port_map.svh ====
/*
 * Constants of the component sorter handler port: field positions, counts and reset values.
 * Assumes inclusion by both the package and the handler port module.
 */
`ifndef SORTER_PORT_MAP_SVH
`define SORTER_PORT_MAP_SVH

// ****************************************
// Counts and positions
// ****************************************
`define SORT_CLASS_COUNT 9
`define SORT_LINE_COUNT 11
`define SORT_OUT_BIT 9
`define SORT_AUX_BIT 10
`define SWEEP_POINT_COUNT 10

// ****************************************
// Reset values of the active-low lines
// ****************************************
`define LINE_IDLE_LEVEL 1'b1
`define SORT_LINES_IDLE 11'h07FF

`endif

// ==== common/sorter_port_pkg.sv ====
/*
 * Types of the component sorter handler port.
 * Assumes sorter_port_map.svh is on the include path.
 */
`include "sorter_port_map.svh"

package sorter_port_pkg;

   // Comparison mode of the port
   typedef enum logic [1:0] {
      MODE_BIN,
      MODE_WHOLE_LIST,
      MODE_STEPPED
   } sort_mode_t;

   // One bin-comparison result from the measurement engine
   typedef struct packed {
      logic [3:0] sort_class;     // 1..9 pass class, 0 none
      logic aux_bin;              // Falls in auxiliary bin
      logic primary_high;         // Above upper class limit
      logic primary_low;          // Below lower class limit
      logic secondary_reject;     // Secondary outside window
   } bin_result_t;

   // One sweep point verdict
   typedef struct packed {
      logic [3:0] point;          // Sweep point index 0..9
      logic out_of_limit;         // Point failed
      logic last;                 // Final point of list
   } sweep_result_t;

endpackage

// ==== rtl/pin_sync.sv ====
/*
 * Two flip-flop synchroniser bank for handler input pins.
 * Assumes asynchronous inputs and one clock.
 */
module pin_sync #(
   parameter int WIDTH = 2
) (
   input wire logic i_core_clk,             // Core clock
   input wire logic i_rst_n,                // Synchronous reset
   input wire logic [WIDTH-1:0] i_async,    // Raw pin levels
   output logic [WIDTH-1:0] o_sync          // Synchronised levels
);

   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] meta_next;
   logic [WIDTH-1:0] sync_reg;
   logic [WIDTH-1:0] sync_next;

   // Refuse an empty bank at elaboration
   if (WIDTH < 1) begin : g_bad_width
      $error("pin_sync width must be positive");
   end

   // Next values of both stages
   always_comb begin
      meta_next = i_async;
      sync_next = meta_reg;
   end

   // Register both stages, idle high
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         meta_reg <= {WIDTH{1'b1}};
         sync_reg <= {WIDTH{1'b1}};
      end else begin
         meta_reg <= meta_next;
         sync_reg <= sync_next;
      end
   end

   assign o_sync = sync_reg;

endmodule // pin_sync

// ==== rtl/sorter_handler_port.sv ====
/*
 * Handler port of a measuring instrument: sort-class and flag outputs, handshake
 * outputs, contact alarm, external trigger and panel lock inputs.
 * Assumes a measurement engine on the same clock that delivers results as pulses,
 * and external open-collector drivers fed from the output enables.
 */
`include "sorter_port_map.svh"

// Function
// R1 - Bin mode: nine classes, out, aux lines
// R2 - Primary high flag above upper limit
// R3 - Primary low flag below lower limit
// R4 - Secondary reject outside secondary window
// R5 - External rising trigger edge starts measurement
// R6 - Panel lock blocks front-panel keys
// R7 - Alarm on open measurement circuit
// R8 - Bin mode analog-done after acquisition
// R9 - Results valid only from measurement-done
// R10 - Measurement-done once data and comparison valid
// R11 - Sweep: ten lines carry point verdicts
// R12 - Sweep: aux carries overall pass/fail
// R13 - Sweep outputs update after whole sweep
// R14 - Whole-list: analog-done after final point
// R15 - Whole-list: measurement-done when all valid
// R16 - All handler outputs active low
// R17 - Stepped: analog-done after each point
// R18 - Stepped: measurement-done after each step
// R19 - Exactly one sort line per result
// R20 - New trigger clears both handshake outputs
module sorter_handler_port #(
   parameter int POINTS = `SWEEP_POINT_COUNT
) (
   input wire logic i_core_clk,                         // Core clock, 25 MHz
   input wire logic i_rst_n,                            // Synchronous reset
   input wire sorter_port_pkg::sort_mode_t i_mode,      // Comparison mode
   input wire logic i_trig_ext_sel,                     // Trigger source external
   input wire logic i_external_trigger_in_n,            // Trigger pin, active low
   input wire logic i_panel_lock_n,                     // Panel lock pin, active low
   input wire logic [7:0] i_panel_keys,                 // Raw front-panel keys
   input wire logic i_open_circuit,                     // Engine contact fault
   input wire logic i_acq_done,                         // Engine acquisition pulse
   input wire logic i_bin_valid,                        // Bin result pulse
   input wire sorter_port_pkg::bin_result_t i_bin,      // Bin result
   input wire logic i_point_valid,                      // Sweep verdict pulse
   input wire sorter_port_pkg::sweep_result_t i_point,  // Sweep verdict
   output logic o_meas_start,                           // Start measurement pulse
   output logic [7:0] o_panel_keys,                     // Keys passed to panel logic
   output logic [`SORT_LINE_COUNT-1:0] o_sort_lines_n,  // Class 1..9, out, aux
   output logic [`SORT_LINE_COUNT-1:0] o_sort_lines_oe, // Open-collector enables
   output logic o_primary_high_flag_n,                  // Primary high, low true
   output logic o_primary_low_flag_n,                   // Primary low, low true
   output logic o_secondary_reject_flag_n,              // Secondary reject
   output logic o_analog_done_n,                        // Analog test finished
   output logic o_measurement_done_n,                   // Results valid
   output logic o_alarm_n,                              // Contact fault alarm
   output logic [3:0] o_flag_oe                         // Enables: high, low, reject, alarm
);

   localparam int LINES = `SORT_LINE_COUNT;

   // Refuse point counts the sort lines cannot carry
   if (POINTS < 1 || POINTS > `SORT_AUX_BIT) begin : g_bad_points
      $error("sweep point count out of range");
   end

   // ****************************************
   // Input pin synchronisation
   // ****************************************
   logic [1:0] pins_sync;

   pin_sync #(
      .WIDTH(2)
   ) u_pin_sync (
      .i_core_clk(i_core_clk),
      .i_rst_n(i_rst_n),
      .i_async({i_external_trigger_in_n, i_panel_lock_n}),
      .o_sync(pins_sync)
   );

   // ****************************************
   // Registered state
   // ****************************************
   logic trig_prev_reg, trig_prev_next;
   logic start_reg, start_next;
   logic [7:0] keys_reg, keys_next;
   logic [LINES-1:0] lines_reg, lines_next;
   logic phi_reg, phi_next;
   logic plo_reg, plo_next;
   logic secondary_reject_flag_reg, secondary_reject_flag_next;
   logic adone_reg, adone_next;
   logic mdone_reg, mdone_next;
   logic alarm_reg, alarm_next;
   logic [POINTS-1:0] acc_reg, acc_next;
   logic last_seen_reg, last_seen_next;
   logic trig_edge;
   logic [3:0] pt_idx;
   logic [LINES-1:0] onehot;
   logic [LINES-1:0] lines_oe_reg, lines_oe_next;
   logic [3:0] flag_oe_reg, flag_oe_next;

   // Rising edge of trigger pin level
   assign trig_edge = pins_sync[1] & ~trig_prev_reg;

   // One-hot class decode, out-of-bin when no pass class
   genvar g;
   generate
      for (g = 0; g < `SORT_CLASS_COUNT; g++) begin : g_class
         assign onehot[g] = ~i_bin.aux_bin && (i_bin.sort_class == 4'(g + 1));
      end
   endgenerate
   assign onehot[`SORT_AUX_BIT] = i_bin.aux_bin;
   assign onehot[`SORT_OUT_BIT] = ~i_bin.aux_bin &&
      (i_bin.sort_class == 4'h0 || i_bin.sort_class > 4'(`SORT_CLASS_COUNT)); // see R19

   assign pt_idx = (i_point.point < 4'(POINTS)) ? i_point.point : 4'(POINTS - 1);

   // Next values of trigger, keys, alarm and results
   always_comb begin
      trig_prev_next = pins_sync[1];
      start_next = i_trig_ext_sel && trig_edge; // see R5
      keys_next = pins_sync[0] ? i_panel_keys : 8'h00; // see R6
      alarm_next = ~i_open_circuit; // see R7, R16
      lines_next = lines_reg;
      phi_next = phi_reg;
      plo_next = plo_reg;
      secondary_reject_flag_next = secondary_reject_flag_reg;
      adone_next = adone_reg;
      mdone_next = mdone_reg;
      acc_next = acc_reg;
      last_seen_next = last_seen_reg;
      if (start_next) begin
         adone_next = `LINE_IDLE_LEVEL; // see R20
         mdone_next = `LINE_IDLE_LEVEL; // see R20
         acc_next = '0;
         last_seen_next = 1'b0;
      end else begin
         case (i_mode)
            sorter_port_pkg::MODE_BIN: begin
               if (i_acq_done) adone_next = 1'b0; // see R8
               if (i_bin_valid) begin
                  lines_next = ~onehot; // see R1, R16, R19
                  phi_next = ~i_bin.primary_high; // see R2
                  plo_next = ~i_bin.primary_low; // see R3
                  secondary_reject_flag_next = ~i_bin.secondary_reject; // see R4
                  mdone_next = 1'b0; // see R9, R10
               end
            end
            sorter_port_pkg::MODE_WHOLE_LIST, sorter_port_pkg::MODE_STEPPED: begin
               if (i_mode == sorter_port_pkg::MODE_STEPPED && i_acq_done) begin
                  adone_next = 1'b0; // see R17
               end
               if (i_mode == sorter_port_pkg::MODE_WHOLE_LIST && i_acq_done && last_seen_reg) begin
                  adone_next = 1'b0; // see R14
               end
               if (i_point_valid) begin
                  acc_next[pt_idx] = i_point.out_of_limit;
                  if (i_mode == sorter_port_pkg::MODE_STEPPED) mdone_next = 1'b0; // see R18
                  if (i_point.last) begin
                     last_seen_next = 1'b1;
                     // Lines change only when the whole list is judged
                     lines_next = `SORT_LINES_IDLE; // see R13
                     lines_next[POINTS-1:0] = ~acc_next; // see R11, R16
                     lines_next[`SORT_AUX_BIT] = ~(|acc_next); // see R12
                     mdone_next = 1'b0; // see R15
                  end
               end
            end
            default: begin
               lines_next = lines_reg;
            end
         endcase
      end
      // Enables follow the levels they pull low, registered like the lines
      lines_oe_next = ~lines_next; // see R1
      flag_oe_next = {~phi_next, ~plo_next, ~secondary_reject_flag_next, ~alarm_next}; // see R16
   end

   // Register all state
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         trig_prev_reg <= `LINE_IDLE_LEVEL; // Idle pin level, no false edge
         start_reg <= 1'b0;
         keys_reg <= 8'h00;
         lines_reg <= `SORT_LINES_IDLE;
         phi_reg <= `LINE_IDLE_LEVEL;
         plo_reg <= `LINE_IDLE_LEVEL;
         secondary_reject_flag_reg <= `LINE_IDLE_LEVEL;
         adone_reg <= `LINE_IDLE_LEVEL;
         mdone_reg <= `LINE_IDLE_LEVEL;
         alarm_reg <= `LINE_IDLE_LEVEL;
         acc_reg <= '0;
         last_seen_reg <= 1'b0;
         lines_oe_reg <= '0;
         flag_oe_reg <= 4'h0;
      end else begin
         trig_prev_reg <= trig_prev_next;
         start_reg <= start_next;
         keys_reg <= keys_next;
         lines_reg <= lines_next;
         phi_reg <= phi_next;
         plo_reg <= plo_next;
         secondary_reject_flag_reg <= secondary_reject_flag_next;
         adone_reg <= adone_next;
         mdone_reg <= mdone_next;
         alarm_reg <= alarm_next;
         acc_reg <= acc_next;
         last_seen_reg <= last_seen_next;
         lines_oe_reg <= lines_oe_next;
         flag_oe_reg <= flag_oe_next;
      end
   end

   // ****************************************
   // Outputs, all straight from flip-flops
   // ****************************************
   assign o_meas_start = start_reg;
   assign o_panel_keys = keys_reg;
   assign o_sort_lines_n = lines_reg;
   assign o_sort_lines_oe = lines_oe_reg; // see R1
   assign o_primary_high_flag_n = phi_reg;
   assign o_primary_low_flag_n = plo_reg;
   assign o_secondary_reject_flag_n = secondary_reject_flag_reg;
   assign o_analog_done_n = adone_reg;
   assign o_measurement_done_n = mdone_reg;
   assign o_alarm_n = alarm_reg;
   assign o_flag_oe = flag_oe_reg;

endmodule // sorter_handler_port

// ==== verif/sorter_port_properties.sv ====
/* Concurrent checks on the sorter handler port outputs.
   Assumes binding into sorter_handler_port and one clock domain. */
module sorter_port_properties #(
   parameter int POINTS = 10
) (
   input wire logic i_core_clk, // Clock
   input wire logic i_rst_n, // Reset
   input wire sorter_port_pkg::sort_mode_t i_mode, // Mode
   input wire logic i_trig_ext_sel, // Source
   input wire logic i_external_trigger_in_n, // Trigger pin
   input wire logic i_open_circuit, // Fault
   input wire logic i_acq_done, // Acquired
   input wire logic i_bin_valid, // Result strobe
   input wire sorter_port_pkg::bin_result_t i_bin, // Result
   input wire logic i_point_valid, // Point strobe
   input wire sorter_port_pkg::sweep_result_t i_point, // Point
   input wire logic o_meas_start, // Start
   input wire logic [10:0] o_sort_lines_n, // Lines
   input wire logic [10:0] o_sort_lines_oe, // Enables
   input wire logic o_primary_high_flag_n, // High
   input wire logic o_primary_low_flag_n, // Low
   input wire logic o_secondary_reject_flag_n, // Reject
   input wire logic o_analog_done_n, // Analog done
   input wire logic o_measurement_done_n, // Results valid
   input wire logic o_alarm_n // Alarm
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_n);

   // Output relations
   property p_oe; o_sort_lines_oe == ~o_sort_lines_n; endproperty
   a_oe: assert property (p_oe) else $error("line enable mismatch");
   property p_alarm; 1'b1 |=> o_alarm_n == !$past(i_open_circuit); endproperty
   a_alarm: assert property (p_alarm) else $error("alarm wrong");
   property p_onehot; i_bin_valid && i_mode == sorter_port_pkg::MODE_BIN
      |=> o_meas_start || $onehot(~o_sort_lines_n) && !o_measurement_done_n; endproperty
   a_onehot: assert property (p_onehot) else $error("sort line not one");
   property p_flags; i_bin_valid && i_mode == sorter_port_pkg::MODE_BIN |=> o_meas_start ||
      {o_primary_high_flag_n, o_primary_low_flag_n, o_secondary_reject_flag_n} == 3'(~$past(i_bin)); endproperty
   a_flags: assert property (p_flags) else $error("flag wrong");
   property p_start; o_meas_start |-> o_analog_done_n && o_measurement_done_n; endproperty
   a_start: assert property (p_start) else $error("done kept on start");
   property p_trig; $rose(i_external_trigger_in_n) && i_trig_ext_sel |-> ##[1:5] o_meas_start; endproperty
   a_trig: assert property (p_trig) else $error("no start");
   property p_stable; i_mode != sorter_port_pkg::MODE_BIN && !(i_point_valid && i_point.last)
      |=> o_meas_start || $stable(o_sort_lines_n); endproperty
   a_stable: assert property (p_stable) else $error("early sweep lines");
   property p_acq; i_acq_done && i_mode != sorter_port_pkg::MODE_WHOLE_LIST
      |=> o_meas_start || !o_analog_done_n; endproperty
   a_acq: assert property (p_acq) else $error("analog done missing");
   c_bin: cover property (i_bin_valid ##1 !o_measurement_done_n);
   c_start: cover property (o_meas_start);
   c_last: cover property (i_point_valid && i_point.last);
endmodule // sorter_port_properties

bind sorter_handler_port sorter_port_properties #(.POINTS(POINTS)) u_props (.*);

// ==== verif/handler_model.sv ====
/* Parts handler model: external trigger pulses and panel lock.
   Assumes calls from the falling clock edge. */
module handler_model (
   input wire logic i_core_clk, // Clock
   output logic o_trig_n, // Trigger pin
   output logic o_lock_n // Lock pin
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      o_trig_n = 1'b1;
      o_lock_n = 1'b1;
   end
   // Low for hold cycles, rising edge requests a test
   task automatic fire(int hold);
      o_trig_n = 1'b0;
      repeat (hold) @(negedge i_core_clk);
      o_trig_n = 1'b1;
   endtask
   // Panel lock level
   task automatic lock(logic on);
      o_lock_n = ~on;
   endtask
endmodule // handler_model

// ==== verif/tb_top.sv ====
/* Random self-checking bench of the sorter handler port.
   Assumes the bound checker and the handler model. */
`define TB_CHK(n, e, a) begin n_tests++; if ((a) !== (e)) begin bad_count++; \
   $display("unexpected %s exp %h got %h", n, e, a); end end
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic i_core_clk = 0, i_rst_n = 0, i_trig_ext_sel = 0, i_open_circuit = 0, i_acq_done = 0;
   logic i_bin_valid = 0, i_point_valid = 0, i_external_trigger_in_n, i_panel_lock_n;
   logic [7:0] i_panel_keys = 8'h00, o_panel_keys;
   sorter_port_pkg::sort_mode_t i_mode = sorter_port_pkg::MODE_BIN;
   sorter_port_pkg::bin_result_t i_bin = 8'h00, b;
   sorter_port_pkg::sweep_result_t i_point = 6'h00;
   logic o_meas_start, o_primary_high_flag_n, o_primary_low_flag_n, o_secondary_reject_flag_n;
   logic o_analog_done_n, o_measurement_done_n, o_alarm_n;
   logic [10:0] o_sort_lines_n, o_sort_lines_oe, held;
   logic [3:0] o_flag_oe;
   logic [1:0] dones;
   logic [6:0] flags_seen;
   int bad_count = 0, n_tests = 0, seed = 87710, k;
   initial forever #20 i_core_clk = ~i_core_clk;
   handler_model u_handler (
      .i_core_clk(i_core_clk),
      .o_trig_n(i_external_trigger_in_n),
      .o_lock_n(i_panel_lock_n)
   );
   sorter_handler_port u_dut (.*);
   // Handshake levels and flag lines as the bench compares them
   assign dones = {o_analog_done_n, o_measurement_done_n};
   assign flags_seen = {o_primary_high_flag_n, o_primary_low_flag_n, o_secondary_reject_flag_n, o_flag_oe};
   // Expected active-low sort lines of one bin result
   function automatic logic [10:0] lines_of(sorter_port_pkg::bin_result_t r);
      lines_of = 11'h7FF;
      if (r.aux_bin) lines_of[10] = 1'b0;
      else if (r.sort_class inside {[1:9]}) lines_of[r.sort_class - 1] = 1'b0;
      else lines_of[9] = 1'b0;
   endfunction
   // Expected active-low flags, then their enables with the alarm idle
   function automatic logic [6:0] flags_of(sorter_port_pkg::bin_result_t r);
      flags_of = {~r.primary_high, ~r.primary_low, ~r.secondary_reject,
         r.primary_high, r.primary_low, r.secondary_reject, 1'b0};
   endfunction
   task automatic tick(int n);
      repeat (n) @(negedge i_core_clk);
   endtask
   task automatic end_of_test;
      if (bad_count == 0 && n_tests > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // Trigger and wait a bounded time for the start pulse
   task automatic start_meas(int hold);
      u_handler.fire(hold);
      for (k = 0; k < 8 && o_meas_start !== 1'b1; k++) tick(1);
      if (k == 8) begin
         bad_count++;
         end_of_test;
      end
      `TB_CHK("done", 2'b11, dones)
   endtask
   // One bin result with its acquisition pulse; strobes stay high between calls
   task automatic send_bin(sorter_port_pkg::bin_result_t v);
      b = v;
      i_bin = b;
      i_bin_valid = 1'b1;
      i_acq_done = 1'b1;
      tick(1);
      `TB_CHK("lines", {lines_of(b), ~lines_of(b)}, {o_sort_lines_n, o_sort_lines_oe})
      `TB_CHK("flags", flags_of(b), flags_seen)
      `TB_CHK("done", 2'b00, dones)
   endtask
   // Ten sweep points with given verdicts; strobes stay high across points
   task automatic sweep(logic step, logic [9:0] verd);
      held = o_sort_lines_n;
      i_point_valid = 1'b1;
      i_acq_done = 1'b1;
      for (int p = 0; p < 10; p++) begin
         i_point = {4'(p), verd[p], p == 9};
         tick(1);
         if (step) `TB_CHK("step", 2'b00, dones)
         else if (p < 9) `TB_CHK("seq", {2'b11, held}, {dones, o_sort_lines_n})
      end
      // Acquisition of the final point completes after its verdict
      i_point_valid = 1'b0;
      tick(1);
      i_acq_done = 1'b0;
      `TB_CHK("sweep", {~(|verd), ~verd, 2'b00}, {o_sort_lines_n, dones})
   endtask
   // Main sequence
   initial begin
      tick(5);
      i_rst_n = 1'b1;
      tick(1);
      `TB_CHK("idle", {11'h7FF, 11'h000, 3'h7}, {o_sort_lines_n, o_sort_lines_oe, dones, o_alarm_n})
      i_trig_ext_sel = 1'b1;
      start_meas(25);
      // Corner classes: class 9, aux over a bad class, none with all flags, class 10
      send_bin(8'h90);
      send_bin(8'hF8);
      send_bin(8'h07);
      send_bin(8'hA0);
      repeat (30) send_bin(8'($random(seed)));
      i_bin_valid = 1'b0;
      i_acq_done = 1'b0;
      i_open_circuit = 1'b1;
      tick(2);
      `TB_CHK("alarm", 2'b01, {o_alarm_n, o_flag_oe[0]})
      i_open_circuit = 1'b0;
      u_handler.lock(1'b1);
      i_panel_keys = 8'($random(seed)) | 8'h01;
      tick(5);
      `TB_CHK("locked", 8'h00, o_panel_keys)
      u_handler.lock(1'b0);
      tick(5);
      `TB_CHK("keys", i_panel_keys, o_panel_keys)
      i_trig_ext_sel = 1'b0;
      u_handler.fire(25);
      repeat (6) begin
         tick(1);
         `TB_CHK("start", 1'b0, o_meas_start)
      end
      i_trig_ext_sel = 1'b1;
      i_mode = sorter_port_pkg::MODE_WHOLE_LIST;
      start_meas(40);
      sweep(1'b0, 10'($random(seed)));
      i_mode = sorter_port_pkg::MODE_STEPPED;
      start_meas(25);
      sweep(1'b1, 10'($random(seed)));
      // Every point in limit: the pass verdict leaves the aux line released
      start_meas(25);
      sweep(1'b1, 10'h000);
      end_of_test;
   end
endmodule // tb_top
